// [rsml_strap_latch.sv]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "rsml_defs.svh"
module rsml_strap_latch #(
	parameter int ADDR_W = `RSML_ADDR_W // address pin count
) (
	input  wire logic                sys_clk,               // 200 MHz clock
	input  wire logic                srst,                  // synchronous reset, high
	input  wire logic [ADDR_W:1]     narrow_if_addr_pins_i, // pin input level
	output logic      [ADDR_W:1]     narrow_if_addr_pins_o, // pin output level
	output logic                     narrow_if_addr_pins_oe,// pin output enable
	input  wire logic                psel,                  // apb select
	input  wire logic                penable,               // apb enable
	input  wire logic                pwrite,                // apb direction
	input  wire logic [11:0]         paddr,                 // apb byte address
	input  wire logic [31:0]         pwdata,                // apb write data
	output logic      [31:0]         prdata,                // apb read data
	output logic                     pready,                // apb ready
	output logic                     pslverr,               // apb error
	output logic                     little_endian,         // byte order
	output logic      [1:0]          boot_mode,             // boot source
	output logic      [1:0]          wide_if_clock_source_sel,   // wide if clock
	output logic      [1:0]          narrow_if_clock_source_sel, // narrow if clock
	output logic                     prom_auto_init,        // start prom init
	output logic                     cell_port_en,          // cell port enabled
	output logic                     serial_port_one_en     // serial port one enabled
);
	// strap positions are fixed on the pin bus, so only the documented pin count is served
	if (ADDR_W != `RSML_ADDR_W) begin : g_bad_width
		$error("rsml_strap_latch: ADDR_W must be 20");
	end

	rsml_mode_if mode ();
	rsml_pkg::rsml_phase_t phase_q;
	logic [ADDR_W:1] straps_q;
	logic [ADDR_W:1] addr_q;
	logic            drive_en_q;
	logic            wr_acc;
	logic            rd_acc;
	logic            hit;
	logic [31:0]     rd_d;

	// phase: capture while reset held, drive after
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_q <= rsml_pkg::RSML_PH_CAPTURE;
		end else begin
			phase_q <= rsml_pkg::RSML_PH_DRIVE;
		end
	end

	// strap snapshot follows pins through reset, frozen after release
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			straps_q <= narrow_if_addr_pins_i;
		end
	end

	// half-word address and tristate control, software owned
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			addr_q     <= '0;
			drive_en_q <= 1'b1;
		end else if (wr_acc && paddr == `RSML_REG_ADDR) begin
			addr_q <= pwdata[ADDR_W-1:0];
		end else if (wr_acc && paddr == `RSML_REG_CTRL) begin
			drive_en_q <= pwdata[0];
		end
	end

	// pins released to straps in reset, driven otherwise only while the drive enable bit is set
	assign narrow_if_addr_pins_o  = addr_q;
	assign narrow_if_addr_pins_oe = (phase_q == rsml_pkg::RSML_PH_DRIVE) && !srst && drive_en_q;

	rsml_decode u_decode (
		.straps (straps_q),
		.mode   (mode)
	);

	// mode outputs come from the frozen snapshot
	assign little_endian              = mode.little_endian;
	assign boot_mode                  = mode.boot_mode;
	assign wide_if_clock_source_sel   = mode.wide_if_clock_source_sel;
	assign narrow_if_clock_source_sel = mode.narrow_if_clock_source_sel;
	// auto-init only once reset has ended
	assign prom_auto_init     = mode.prom_auto_init && (phase_q == rsml_pkg::RSML_PH_DRIVE) && !srst;
	assign cell_port_en       = mode.cell_port_en;
	assign serial_port_one_en = mode.serial_port_one_en;

	// apb slave: zero wait, unmapped addresses error
	assign wr_acc  = psel && penable && pwrite && !srst;
	assign rd_acc  = psel && !pwrite;
	assign hit     = (paddr == `RSML_REG_STRAPS) || (paddr == `RSML_REG_MODE)
		|| (paddr == `RSML_REG_ADDR) || (paddr == `RSML_REG_CTRL);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	// read mux
	always_comb begin
		rd_d = 32'h0000_0000;
		case (paddr)
			`RSML_REG_STRAPS: rd_d[ADDR_W-1:0] = straps_q;
			`RSML_REG_MODE: begin
				rd_d[`RSML_MODE_ENDIAN]                     = mode.little_endian;
				rd_d[`RSML_MODE_BOOT_LO+1:`RSML_MODE_BOOT_LO] = mode.boot_mode;
				rd_d[`RSML_MODE_WCLK_LO+1:`RSML_MODE_WCLK_LO] = mode.wide_if_clock_source_sel;
				rd_d[`RSML_MODE_NCLK_LO+1:`RSML_MODE_NCLK_LO] = mode.narrow_if_clock_source_sel;
				rd_d[`RSML_MODE_PROM]                       = mode.prom_auto_init;
				rd_d[`RSML_MODE_CELL]                       = mode.cell_port_en;
				rd_d[`RSML_MODE_SER1]                       = mode.serial_port_one_en;
				rd_d[`RSML_MODE_RSVD]                       = mode.reserved_seen;
				rd_d[`RSML_MODE_PULLERR]                    = mode.pullup_fault;
			end
			`RSML_REG_ADDR: rd_d[ADDR_W-1:0] = addr_q;
			`RSML_REG_CTRL: rd_d[0] = drive_en_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end
	assign prdata = rd_acc ? rd_d : 32'h0000_0000;

	// snapshot never moves outside reset
	property p_straps_hold;
		@(posedge sys_clk) disable iff (srst) !$rose(srst) |=> $stable(straps_q);
	endproperty
	a_straps_hold: assert property (p_straps_hold) else $error("straps changed after reset");

	// pins not driven while reset is held
	property p_no_drive_in_reset;
		@(posedge sys_clk) srst |-> !narrow_if_addr_pins_oe;
	endproperty
	a_no_drive_in_reset: assert property (p_no_drive_in_reset) else $error("pins driven in reset");

	// pins driven from the cycle after reset release
	property p_drive_after;
		@(posedge sys_clk) disable iff (srst) $fell(srst) |=> narrow_if_addr_pins_oe == drive_en_q;
	endproperty
	a_drive_after: assert property (p_drive_after) else $error("pins not driven after reset");

	// snapshot equals pins seen on the last reset edge
	property p_capture;
		@(posedge sys_clk) $fell(srst) |-> straps_q == $past(narrow_if_addr_pins_i);
	endproperty
	a_capture: assert property (p_capture) else $error("strap capture mismatch");

	property p_endian;
		@(posedge sys_clk) disable iff (srst) little_endian == straps_q[`RSML_ENDIAN_BIT];
	endproperty
	a_endian: assert property (p_endian) else $error("endian mismatch");

	property p_boot;
		@(posedge sys_clk) disable iff (srst) straps_q[19:18] != 2'b11 |-> boot_mode == straps_q[19:18];
	endproperty
	a_boot: assert property (p_boot) else $error("boot mismatch");

	property p_wclk;
		@(posedge sys_clk) disable iff (srst) straps_q[17:16] != 2'b11 |-> wide_if_clock_source_sel == straps_q[17:16];
	endproperty
	a_wclk: assert property (p_wclk) else $error("wide clock mismatch");

	property p_nclk;
		@(posedge sys_clk) disable iff (srst) straps_q[15:14] != 2'b11 |-> narrow_if_clock_source_sel == straps_q[15:14];
	endproperty
	a_nclk: assert property (p_nclk) else $error("narrow clock mismatch");

	property p_prom;
		@(posedge sys_clk) disable iff (srst) !$fell(srst) |-> prom_auto_init == straps_q[`RSML_PROM_BIT];
	endproperty
	a_prom: assert property (p_prom) else $error("prom init mismatch");

	property p_cell;
		@(posedge sys_clk) disable iff (srst) cell_port_en != serial_port_one_en && cell_port_en == straps_q[11];
	endproperty
	a_cell: assert property (p_cell) else $error("cell/serial select wrong");

	// reserved boot code falls back to no boot
	property p_boot_rsvd;
		@(posedge sys_clk) disable iff (srst) straps_q[`RSML_BOOT_HI:`RSML_BOOT_LO] == 2'b11 |-> boot_mode == 2'b00;
	endproperty
	a_boot_rsvd: assert property (p_boot_rsvd) else $error("reserved boot code not mapped");

	// reserved wide clock code falls back to the external input
	property p_wclk_rsvd;
		@(posedge sys_clk) disable iff (srst) straps_q[`RSML_WCLK_HI:`RSML_WCLK_LO] == 2'b11
			|-> wide_if_clock_source_sel == 2'b00;
	endproperty
	a_wclk_rsvd: assert property (p_wclk_rsvd) else $error("reserved wide clock not mapped");

	// reserved narrow clock code falls back to the external input
	property p_nclk_rsvd;
		@(posedge sys_clk) disable iff (srst) straps_q[`RSML_NCLK_HI:`RSML_NCLK_LO] == 2'b11
			|-> narrow_if_clock_source_sel == 2'b00;
	endproperty
	a_nclk_rsvd: assert property (p_nclk_rsvd) else $error("reserved narrow clock not mapped");

	// auto-init held off for the whole of reset
	property p_prom_in_reset;
		@(posedge sys_clk) srst |-> !prom_auto_init;
	endproperty
	a_prom_in_reset: assert property (p_prom_in_reset) else $error("prom init during reset");

	// decoded modes other than auto-init and serial port one hold still between resets
	property p_modes_hold;
		@(posedge sys_clk) disable iff (srst) !$fell(srst) |-> $stable(little_endian) && $stable(boot_mode)
			&& $stable(wide_if_clock_source_sel) && $stable(narrow_if_clock_source_sel) && $stable(cell_port_en);
	endproperty
	a_modes_hold: assert property (p_modes_hold) else $error("modes changed after reset");

	// a write to the address register shows on the pins next cycle
	property p_addr_write;
		@(posedge sys_clk) disable iff (srst) wr_acc && paddr == `RSML_REG_ADDR
			|=> narrow_if_addr_pins_o == $past(pwdata[ADDR_W-1:0]);
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("address write not on pins");

	// the drive enable bit gates the pins from the next cycle
	property p_ctrl_write;
		@(posedge sys_clk) disable iff (srst) wr_acc && paddr == `RSML_REG_CTRL |=> narrow_if_addr_pins_oe == $past(pwdata[0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("drive enable not applied");
endmodule

// [rsml_defs.svh]
`ifndef RSML_DEFS_SVH
`define RSML_DEFS_SVH
// pin bus spans narrow_if_addr_pins[20:1]
`define RSML_ADDR_MSB      20
`define RSML_ADDR_LSB      1
`define RSML_ADDR_W        20
// strap positions on the address pins
`define RSML_ENDIAN_BIT    20
`define RSML_BOOT_HI       19
`define RSML_BOOT_LO       18
`define RSML_WCLK_HI       17
`define RSML_WCLK_LO       16
`define RSML_NCLK_HI       15
`define RSML_NCLK_LO       14
`define RSML_PROM_BIT      13
`define RSML_CELL_BIT      11
`define RSML_PULLUP_HI     9
`define RSML_PULLUP_LO     8
// APB register byte addresses
`define RSML_REG_STRAPS    12'h000
`define RSML_REG_MODE      12'h004
`define RSML_REG_ADDR      12'h008
`define RSML_REG_CTRL      12'h00C
// documented strap defaults; unused, the straps snapshot has no reset value
`define RSML_STRAP_RESET   20'h8_0000
`define RSML_BOOT_RESET    2'b10
// fields of the decoded-mode register
`define RSML_MODE_ENDIAN   0
`define RSML_MODE_BOOT_LO  1
`define RSML_MODE_WCLK_LO  3
`define RSML_MODE_NCLK_LO  5
`define RSML_MODE_PROM     7
`define RSML_MODE_CELL     8
`define RSML_MODE_SER1     9
`define RSML_MODE_RSVD     10
`define RSML_MODE_PULLERR  11
`endif

// [rsml_pkg.sv]
package rsml_pkg;
	// boot source codes
	typedef enum logic [1:0] {
		RSML_BOOT_NONE = 2'b00,
		RSML_BOOT_HOST = 2'b01,
		RSML_BOOT_ROM8 = 2'b10,
		RSML_BOOT_RSVD = 2'b11
	} rsml_boot_t;
	// memory interface clock source codes
	typedef enum logic [1:0] {
		RSML_CLK_EXT   = 2'b00,
		RSML_CLK_DIV4  = 2'b01,
		RSML_CLK_DIV6  = 2'b10,
		RSML_CLK_RSVD  = 2'b11
	} rsml_clk_t;
	// pin phase
	typedef enum logic [1:0] {
		RSML_PH_CAPTURE = 2'b01,
		RSML_PH_DRIVE   = 2'b10
	} rsml_phase_t;
endpackage

// [rsml_mode_if.sv]
`timescale 1ns/1ps
// decoded operating modes handed from the decoder to the top
interface rsml_mode_if;
	logic               little_endian;
	rsml_pkg::rsml_boot_t boot_mode;
	rsml_pkg::rsml_clk_t  wide_if_clock_source_sel;
	rsml_pkg::rsml_clk_t  narrow_if_clock_source_sel;
	logic               prom_auto_init;
	logic               cell_port_en;
	logic               serial_port_one_en;
	logic               reserved_seen;
	logic               pullup_fault;
	modport src (output little_endian, boot_mode, wide_if_clock_source_sel, narrow_if_clock_source_sel,
		prom_auto_init, cell_port_en, serial_port_one_en, reserved_seen, pullup_fault);
	modport dst (input little_endian, boot_mode, wide_if_clock_source_sel, narrow_if_clock_source_sel,
		prom_auto_init, cell_port_en, serial_port_one_en, reserved_seen, pullup_fault);
endinterface

// [rsml_decode.sv]
`timescale 1ns/1ps
`include "rsml_defs.svh"
// turns the latched strap word into mode selections
module rsml_decode (
	input  wire logic [`RSML_ADDR_MSB:`RSML_ADDR_LSB] straps, // latched strap word
	rsml_mode_if.src                                  mode    // decoded modes
);
	logic [1:0] boot_c;
	logic [1:0] wclk_c;
	logic [1:0] nclk_c;
	assign boot_c = straps[`RSML_BOOT_HI:`RSML_BOOT_LO];
	assign wclk_c = straps[`RSML_WCLK_HI:`RSML_WCLK_LO];
	assign nclk_c = straps[`RSML_NCLK_HI:`RSML_NCLK_LO];
	// endian: 1 little (default), 0 big
	assign mode.little_endian = straps[`RSML_ENDIAN_BIT];
	// reserved boot code falls back to no boot
	assign mode.boot_mode = (boot_c == 2'b11) ? rsml_pkg::RSML_BOOT_NONE : rsml_pkg::rsml_boot_t'(boot_c);
	// reserved clock codes fall back to the external input
	assign mode.wide_if_clock_source_sel = (wclk_c == 2'b11) ? rsml_pkg::RSML_CLK_EXT
		: rsml_pkg::rsml_clk_t'(wclk_c);
	assign mode.narrow_if_clock_source_sel = (nclk_c == 2'b11) ? rsml_pkg::RSML_CLK_EXT
		: rsml_pkg::rsml_clk_t'(nclk_c);
	assign mode.prom_auto_init = straps[`RSML_PROM_BIT];
	// cell port and serial port one are mutually exclusive
	assign mode.cell_port_en       = straps[`RSML_CELL_BIT];
	assign mode.serial_port_one_en = ~straps[`RSML_CELL_BIT];
	assign mode.reserved_seen = (boot_c == 2'b11) | (wclk_c == 2'b11) | (nclk_c == 2'b11);
	// board must hold bits 8 and 9 high; flag if not
	assign mode.pullup_fault = ~(straps[`RSML_PULLUP_HI] & straps[`RSML_PULLUP_LO]);
endmodule

// [rsml_board.sv]
`timescale 1ns/1ps
// board strapping plus bus wire: pulls set the level whenever the device lets the pins float
module rsml_board (
	input  wire logic [20:1] strap_word, // resistor pattern fitted on the board
	input  wire logic        pci_en,     // pci peripheral enable strap
	input  wire logic [20:1] pins_o,     // device address drive
	input  wire logic        pins_oe,    // device drives the pins
	output logic      [20:1] pins_i      // resolved wire level
);
	logic [20:1] pulled;
	// prom strap kept low without pci, bits 9 and 8 always pulled up
	assign pulled = {strap_word[20:14], strap_word[13] & pci_en, strap_word[12:10], 2'b11, strap_word[7:1]};
	// a driven wire shows the address, a released one falls back to the pulls
	assign pins_i = pins_oe ? pins_o : pulled;
endmodule

// [rsml_strap_latch_bench.sv]
`timescale 1ns/1ps
module rsml_strap_latch_bench;
	logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pci_en = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, a;
	logic [20:1] strap = 20'h8_0300, s, pins_i, pins_o;
	logic [1:0]  boot_mode, wclk, nclk;
	logic        pready, pslverr, er, oe, little_endian, prom_auto_init, cell_port_en, serial_port_one_en;
	int          err_total = 0, checks = 0, seed = 32'h0ba3_ab31;
	// half period of the 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	rsml_board i_board (.strap_word(strap), .pci_en(pci_en), .pins_o(pins_o), .pins_oe(oe), .pins_i(pins_i));
	rsml_strap_latch i_dut (.sys_clk(sys_clk), .srst(srst), .narrow_if_addr_pins_i(pins_i),
		.narrow_if_addr_pins_o(pins_o), .narrow_if_addr_pins_oe(oe), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.little_endian(little_endian), .boot_mode(boot_mode), .wide_if_clock_source_sel(wclk),
		.narrow_if_clock_source_sel(nclk), .prom_auto_init(prom_auto_init), .cell_port_en(cell_port_en),
		.serial_port_one_en(serial_port_one_en));
	// expected decoded-mode word for a strap pattern; reserved codes fall back to code 00
	function automatic logic [31:0] exp_mode(input logic [20:1] v);
		logic [1:0] b, w, n;
		b = (v[19:18] == 2'b11) ? 2'b00 : v[19:18];
		w = (v[17:16] == 2'b11) ? 2'b00 : v[17:16];
		n = (v[15:14] == 2'b11) ? 2'b00 : v[15:14];
		exp_mode = {20'h0_0000, 1'b0, (&v[19:18]) | (&v[17:16]) | (&v[15:14]), ~v[11], v[11], v[13], n, w, b, v[20]};
	endfunction
	// one comparison, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer: setup, then access until pready at a rising edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		close_out();
	end
	// random strap patterns, the first four setting every code in each two-bit field
	initial begin
		for (int it = 0; it < 12; it++) begin
			s = $random(seed);
			s[9:8] = 2'b11;
			pci_en <= $random(seed);
			@(posedge sys_clk);
			s[13] = s[13] & pci_en;
			if (it < 4) s[19:14] = {3{it[1:0]}};
			strap <= s; srst <= 1'b1;
			repeat (7) @(posedge sys_clk);
			#1 chk("oe in reset", 32'(1'b0), 32'(oe));
			chk("prom in reset", 32'(1'b0), 32'(prom_auto_init));
			@(posedge sys_clk);
			srst <= 1'b0;
			@(posedge sys_clk);
			#1 chk("oe after reset", 32'(1'b1), 32'(oe));
			chk("mode ports", exp_mode(s) & 32'h0000_03ff, {22'h00_0000, serial_port_one_en, cell_port_en,
				prom_auto_init, nclk, wclk, boot_mode, little_endian});
			apb(1'b0, 12'h000, 32'h0000_0000);
			chk("straps reg", {12'h000, s}, rd);
			apb(1'b0, 12'h004, 32'h0000_0000);
			chk("mode reg", exp_mode(s), rd);
			a = $random(seed);
			apb(1'b1, 12'h008, a);
			@(posedge sys_clk);
			#1 chk("address pins", {12'h000, a[19:0]}, {12'h000, pins_o});
			strap <= ~s;
			apb(1'b1, 12'h000, a);
			apb(1'b0, 12'h000, 32'h0000_0000);
			chk("straps held", {12'h000, s}, rd);
			chk("modes held", exp_mode(s) & 32'h0000_03ff, {22'h00_0000, serial_port_one_en, cell_port_en,
				prom_auto_init, nclk, wclk, boot_mode, little_endian});
			apb(1'b1, 12'h00C, 32'h0000_0000);
			@(posedge sys_clk);
			#1 chk("oe released", 32'(1'b0), 32'(oe));
			apb(1'b1, 12'h00C, 32'h0000_0001);
			apb(1'b0, 12'h010, 32'h0000_0000);
			chk("unmapped error", 32'(1'b1), 32'(er));
			chk("unmapped data", 32'h0000_0000, rd);
		end
		close_out();
	end
endmodule
